// >>> core/cmpd_decoder.sv
// Control-mode strap decoder with an AXI4-Lite register slave
`timescale 1ns/1ps
module cmpd_decoder
    import cmpd_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // Mode select straps
    input  wire logic        primary_sel_level,
    input  wire logic        primary_sel_floating,
    input  wire logic        secondary_sel_level,
    input  wire logic        secondary_sel_floating,
    // Shared three-level pins
    input  wire logic        range_mode_level,
    input  wire logic        range_mode_floating,
    input  wire logic        swing_pin_level,
    input  wire logic        swing_pin_floating,
    input  wire logic        edge_pin_level,
    input  wire logic        edge_pin_floating,
    input  wire logic        delay_pin_level,
    input  wire logic        delay_pin_floating,
    // Effective settings
    output logic             extended_mode_r,
    output logic             output_swing_level_r,
    output logic             output_transition_edge_r,
    output logic             ddr_clock_r,
    output logic             calibration_delay_select_r,
    output logic             dual_edge_sampling_r,
    output logic             input_full_scale_range_r,
    output logic             swing_float_error_r,
    // Serial interface taps
    output logic             serial_clock_r,
    output logic             serial_line_data_r,
    output logic             serial_select_n_r,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    cmpd_tl_t prim_tl;
    cmpd_tl_t sec_tl;
    cmpd_tl_t rng_tl;
    cmpd_tl_t swg_tl;
    cmpd_tl_t edg_tl;
    cmpd_tl_t dly_tl;

    logic                 ext_nxt;
    logic [CMPD_NSET-1:0] set_nxt;
    logic [CMPD_NSET-1:0] ctrl_r;
    logic [CMPD_NSET-1:0] set_bus;

    logic        aw_fire;
    logic        w_fire;
    logic        ar_fire;
    logic        aw_hold_r;
    logic        aw_hold_nxt;
    logic        w_hold_r;
    logic        w_hold_nxt;
    logic        do_wr;
    logic        bvalid_nxt;
    logic        rvalid_nxt;
    logic [3:0]  awaddr_r;
    logic [3:0]  wr_addr;
    logic [31:0] wdata_r;
    logic [31:0] wr_data;
    logic [3:0]  wstrb_r;
    logic [3:0]  wr_strb;

    // Pad readers, one per three-level pin
    cmpd_tri_level u_prim (.sys_clk(sys_clk), .arst_n(arst_n),
        .pin_level(primary_sel_level),
        .pin_floating(primary_sel_floating), .level_r(prim_tl));
    cmpd_tri_level u_sec (.sys_clk(sys_clk), .arst_n(arst_n),
        .pin_level(secondary_sel_level),
        .pin_floating(secondary_sel_floating), .level_r(sec_tl));
    cmpd_tri_level u_rng (.sys_clk(sys_clk), .arst_n(arst_n),
        .pin_level(range_mode_level),
        .pin_floating(range_mode_floating), .level_r(rng_tl));
    cmpd_tri_level u_swg (.sys_clk(sys_clk), .arst_n(arst_n),
        .pin_level(swing_pin_level),
        .pin_floating(swing_pin_floating), .level_r(swg_tl));
    cmpd_tri_level u_edg (.sys_clk(sys_clk), .arst_n(arst_n),
        .pin_level(edge_pin_level),
        .pin_floating(edge_pin_floating), .level_r(edg_tl));
    cmpd_tri_level u_dly (.sys_clk(sys_clk), .arst_n(arst_n),
        .pin_level(delay_pin_level),
        .pin_floating(delay_pin_floating), .level_r(dly_tl));

    // Control mode decode from the two select straps and the range pin
    always_comb begin
        if (prim_tl == CMPD_TL_HIGH) begin
            ext_nxt = 1'b0;
        end else if (prim_tl == CMPD_TL_LOW) begin
            ext_nxt = 1'b1;
        // range pin decides when primary open and secondary high or open
        end else if (sec_tl != CMPD_TL_LOW) begin
            ext_nxt = (rng_tl == CMPD_TL_FLOAT);
        end else begin
            ext_nxt = 1'b0; // Secondary pulled low keeps pin mode
        end
    end

    // Settings seen by the core in each mode
    always_comb begin
        set_nxt = ctrl_r;
        // pin mode ignores the software settings
        if (!ext_nxt) begin
            set_nxt[CMPD_F_SWING] = (swg_tl == CMPD_TL_HIGH);
            // edge pin picks data transition edge
            set_nxt[CMPD_F_EDGE]  = (edg_tl == CMPD_TL_HIGH);
            // open edge pin runs a DDR clock
            set_nxt[CMPD_F_DDR]   = (edg_tl == CMPD_TL_FLOAT);
            set_nxt[CMPD_F_CDLY]  = (dly_tl == CMPD_TL_HIGH);
            // open delay pin gives short plus dual-edge
            set_nxt[CMPD_F_DES]   = (dly_tl == CMPD_TL_FLOAT);
            // range pin low reduced, high normal
            set_nxt[CMPD_F_RANGE] = (rng_tl == CMPD_TL_HIGH);
        end
    end

    // Effective settings, registered
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            extended_mode_r            <= 1'b0;
            output_swing_level_r       <= 1'b0;
            output_transition_edge_r   <= 1'b0;
            ddr_clock_r                <= 1'b0;
            calibration_delay_select_r <= 1'b0;
            dual_edge_sampling_r       <= 1'b0;
            input_full_scale_range_r   <= 1'b0;
        end else begin
            extended_mode_r            <= ext_nxt;
            output_swing_level_r       <= set_nxt[CMPD_F_SWING];
            output_transition_edge_r   <= set_nxt[CMPD_F_EDGE];
            ddr_clock_r                <= set_nxt[CMPD_F_DDR];
            calibration_delay_select_r <= set_nxt[CMPD_F_CDLY];
            dual_edge_sampling_r       <= set_nxt[CMPD_F_DES];
            input_full_scale_range_r   <= set_nxt[CMPD_F_RANGE];
        end
    end

    // Strapping fault and serial taps
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            swing_float_error_r <= 1'b0;
            serial_clock_r      <= 1'b0;
            serial_line_data_r  <= 1'b0;
            serial_select_n_r   <= 1'b1;
        end else begin
            // an open swing pin in pin mode is flagged
            swing_float_error_r <= !ext_nxt && (swg_tl == CMPD_TL_FLOAT);
            serial_clock_r     <= ext_nxt && (swg_tl == CMPD_TL_HIGH);
            serial_line_data_r <= ext_nxt && (edg_tl == CMPD_TL_HIGH);
            serial_select_n_r  <= !ext_nxt || (dly_tl != CMPD_TL_LOW);
        end
    end

    // Bus handshakes
    assign aw_fire = s_awvalid && s_awready;
    assign w_fire  = s_wvalid && s_wready;
    assign ar_fire = s_arvalid && s_arready;
    assign set_bus = {input_full_scale_range_r, dual_edge_sampling_r,
                      calibration_delay_select_r, ddr_clock_r,
                      output_transition_edge_r, output_swing_level_r};

    // Write channel bookkeeping; address and data in either order
    always_comb begin
        aw_hold_nxt = aw_hold_r || aw_fire;
        w_hold_nxt  = w_hold_r || w_fire;
        wr_addr     = aw_fire ? s_awaddr : awaddr_r;
        wr_data     = w_fire ? s_wdata : wdata_r;
        wr_strb     = w_fire ? s_wstrb : wstrb_r;
        do_wr       = aw_hold_nxt && w_hold_nxt && !s_bvalid;
        if (do_wr) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
        end
        bvalid_nxt = (s_bvalid && !s_bready) || do_wr;
        rvalid_nxt = (s_rvalid && !s_rready) || ar_fire;
    end

    // Write side registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 4'h0;
            wdata_r   <= 32'h0;
            wstrb_r   <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= CMPD_RESP_OK;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            if (aw_fire) begin
                awaddr_r <= s_awaddr;
            end
            if (w_fire) begin
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end
            s_awready <= !aw_hold_nxt && !bvalid_nxt;
            s_wready  <= !w_hold_nxt && !bvalid_nxt;
            s_bvalid  <= bvalid_nxt;
            if (do_wr) begin
                s_bresp <= (wr_addr == CMPD_CTRL_OFS ||
                            wr_addr == CMPD_STAT_OFS) ?
                           CMPD_RESP_OK : CMPD_RESP_ERR;
            end
        end
    end

    // Serial-mode settings written by software, low byte lane only
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= CMPD_CTRL_RST;
        end else if (do_wr && wr_addr == CMPD_CTRL_OFS && wr_strb[0]) begin
            ctrl_r <= wr_data[CMPD_NSET-1:0];
        end
    end

    // Read side
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= CMPD_RESP_OK;
        end else begin
            s_arready <= !rvalid_nxt;
            s_rvalid  <= rvalid_nxt;
            if (ar_fire) begin
                s_rdata <= 32'h0;
                s_rresp <= CMPD_RESP_OK;
                unique case (s_araddr)
                    CMPD_CTRL_OFS: begin
                        s_rdata[CMPD_NSET-1:0] <= ctrl_r;
                    end
                    CMPD_STAT_OFS: begin
                        s_rdata[CMPD_S_EXT]  <= extended_mode_r;
                        s_rdata[CMPD_S_FERR] <= swing_float_error_r;
                        s_rdata[CMPD_S_SET +: CMPD_NSET] <= set_bus;
                    end
                    default: begin
                        s_rresp <= CMPD_RESP_ERR;
                    end
                endcase
            end
        end
    end

    // Checks on decode and bus behaviour
    property p_prim_high;
        @(posedge sys_clk) disable iff (!arst_n)
        prim_tl == CMPD_TL_HIGH |=> !extended_mode_r;
    endproperty
    a_prim_high: assert property (p_prim_high)
        else $error("primary high did not give pin mode");

    property p_range_decides;
        @(posedge sys_clk) disable iff (!arst_n)
        (prim_tl == CMPD_TL_FLOAT && sec_tl != CMPD_TL_LOW)
        |=> extended_mode_r == $past(rng_tl == CMPD_TL_FLOAT);
    endproperty
    a_range_decides: assert property (p_range_decides)
        else $error("range pin did not pick the mode");

    property p_prim_low;
        @(posedge sys_clk) disable iff (!arst_n)
        prim_tl == CMPD_TL_LOW |=> extended_mode_r;
    endproperty
    a_prim_low: assert property (p_prim_low)
        else $error("primary low did not give serial mode");

    property p_range_sel;
        @(posedge sys_clk) disable iff (!arst_n)
        (!ext_nxt && rng_tl != CMPD_TL_FLOAT)
        |=> input_full_scale_range_r == $past(rng_tl == CMPD_TL_HIGH);
    endproperty
    a_range_sel: assert property (p_range_sel)
        else $error("full scale range wrong in pin mode");

    property p_edge_sel;
        @(posedge sys_clk) disable iff (!arst_n)
        (!ext_nxt && edg_tl != CMPD_TL_FLOAT) |=> !ddr_clock_r &&
        output_transition_edge_r == $past(edg_tl == CMPD_TL_HIGH);
    endproperty
    a_edge_sel: assert property (p_edge_sel)
        else $error("output edge wrong in pin mode");

    property p_ddr;
        @(posedge sys_clk) disable iff (!arst_n)
        (!ext_nxt && edg_tl == CMPD_TL_FLOAT) |=> ddr_clock_r;
    endproperty
    a_ddr: assert property (p_ddr)
        else $error("open edge pin did not give DDR");

    property p_delay_des;
        @(posedge sys_clk) disable iff (!arst_n)
        (!ext_nxt && dly_tl == CMPD_TL_FLOAT)
        |=> dual_edge_sampling_r && !calibration_delay_select_r;
    endproperty
    a_delay_des: assert property (p_delay_des)
        else $error("open delay pin did not give short dual-edge");

    property p_swing_err;
        @(posedge sys_clk) disable iff (!arst_n)
        (!ext_nxt && swg_tl == CMPD_TL_FLOAT) |=> swing_float_error_r;
    endproperty
    a_swing_err: assert property (p_swing_err)
        else $error("open swing pin not flagged");

    property p_serial_idle;
        @(posedge sys_clk) disable iff (!arst_n)
        !extended_mode_r |-> serial_select_n_r && !serial_clock_r;
    endproperty
    a_serial_idle: assert property (p_serial_idle)
        else $error("serial lines active in pin mode");

    property p_bresp_in_time;
        @(posedge sys_clk) disable iff (!arst_n)
        do_wr |=> s_bvalid;
    endproperty
    a_bresp_in_time: assert property (p_bresp_in_time)
        else $error("write response not raised");

    property p_ctrl_ignored;
        @(posedge sys_clk) disable iff (!arst_n)
        (!ext_nxt && $changed(ctrl_r) && $stable(swg_tl))
        |=> $stable(output_swing_level_r);
    endproperty
    a_ctrl_ignored: assert property (p_ctrl_ignored)
        else $error("software setting leaked into pin mode");

    c_serial_mode: cover property (@(posedge sys_clk)
        disable iff (!arst_n) $rose(extended_mode_r));
    c_ddr_mode: cover property (@(posedge sys_clk)
        disable iff (!arst_n) ddr_clock_r && !extended_mode_r);
    c_write: cover property (@(posedge sys_clk)
        disable iff (!arst_n) s_bvalid && s_bready);
    c_read_err: cover property (@(posedge sys_clk)
        disable iff (!arst_n) s_rvalid && s_rresp == CMPD_RESP_ERR);
endmodule : cmpd_decoder

// >>> core/cmpd_pkg.sv
// Constants and types shared by the control-mode pin decoder
package cmpd_pkg;
    // Three-level pin reading
    typedef enum logic [1:0] {
        CMPD_TL_LOW   = 2'h0,
        CMPD_TL_HIGH  = 2'h1,
        CMPD_TL_FLOAT = 2'h2
    } cmpd_tl_t;

    // Register byte offsets
    localparam logic [3:0] CMPD_CTRL_OFS = 4'h0;
    localparam logic [3:0] CMPD_STAT_OFS = 4'h4;

    // Settings field positions (CTRL and STAT[13:8])
    localparam int CMPD_F_SWING = 0;
    localparam int CMPD_F_EDGE  = 1;
    localparam int CMPD_F_DDR   = 2;
    localparam int CMPD_F_CDLY  = 3;
    localparam int CMPD_F_DES   = 4;
    localparam int CMPD_F_RANGE = 5;
    localparam int CMPD_NSET    = 6;
    // Status field positions
    localparam int CMPD_S_EXT   = 0;
    localparam int CMPD_S_FERR  = 1;
    localparam int CMPD_S_SET   = 8;

    // Values after reset and bus response codes
    localparam logic [5:0] CMPD_CTRL_RST = 6'h21;
    localparam logic [1:0] CMPD_RESP_OK  = 2'h0;
    localparam logic [1:0] CMPD_RESP_ERR = 2'h2;
endpackage : cmpd_pkg

// >>> core/cmpd_tri_level.sv
// Registered reader for one three-level strap pin
`timescale 1ns/1ps
module cmpd_tri_level
    import cmpd_pkg::*;
(
    // Clock and reset
    input  wire logic     sys_clk,
    input  wire logic     arst_n,
    // Pad sense
    input  wire logic     pin_level,
    input  wire logic     pin_floating,
    // Decoded reading
    output cmpd_tl_t      level_r
);
    // Floating sense wins over the weak level seen on an open pin
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            level_r <= CMPD_TL_FLOAT;
        end else if (pin_floating) begin
            level_r <= CMPD_TL_FLOAT;
        end else begin
            level_r <= pin_level ? CMPD_TL_HIGH : CMPD_TL_LOW;
        end
    end
endmodule : cmpd_tri_level

// >>> testbench/cmpd_strap_model.sv
// Board strapping and host pin driver facing the decoder pads
`timescale 1ns/1ps
module cmpd_strap_model
    import cmpd_pkg::*;
(
    // Clock
    input  wire logic      sys_clk,
    // Requested pin states
    input  wire cmpd_tl_t  prim_req,
    input  wire cmpd_tl_t  sec_req,
    input  wire cmpd_tl_t  rng_req,
    input  wire cmpd_tl_t  swg_req,
    input  wire cmpd_tl_t  edg_req,
    input  wire cmpd_tl_t  dly_req,
    // Pad levels and open-pin sense
    output logic           primary_sel_level,
    output logic           primary_sel_floating,
    output logic           secondary_sel_level,
    output logic           secondary_sel_floating,
    output logic           range_mode_level,
    output logic           range_mode_floating,
    output logic           swing_pin_level,
    output logic           swing_pin_floating,
    output logic           edge_pin_level,
    output logic           edge_pin_floating,
    output logic           delay_pin_level,
    output logic           delay_pin_floating
);
    logic wiggle_r = 1'b0;

    // An open pad shows a level that changes every cycle
    always @(posedge sys_clk) begin
        wiggle_r <= ~wiggle_r;
    end

    // Open flag and level for one pin
    function automatic logic [1:0] pad(input cmpd_tl_t s, input logic w);
        return {s == CMPD_TL_FLOAT,
                (s == CMPD_TL_FLOAT) ? w : s == CMPD_TL_HIGH};
    endfunction : pad

    // Straps and shared pins
    assign {primary_sel_floating, primary_sel_level} = pad(prim_req, wiggle_r);
    assign {secondary_sel_floating, secondary_sel_level} =
        pad(sec_req, ~wiggle_r);
    assign {range_mode_floating, range_mode_level} = pad(rng_req, wiggle_r);
    // swing pin left open only on purpose
    assign {swing_pin_floating, swing_pin_level} = pad(swg_req, ~wiggle_r);
    assign {edge_pin_floating, edge_pin_level} = pad(edg_req, wiggle_r);
    assign {delay_pin_floating, delay_pin_level} = pad(dly_req, ~wiggle_r);
endmodule : cmpd_strap_model

// >>> testbench/control_mode_pin_decoder_test.sv
// Self-checking bench for the control-mode strap decoder
`timescale 1ns/1ps
module control_mode_pin_decoder_test
    import cmpd_pkg::*;
;
    localparam cmpd_tl_t    L   = CMPD_TL_LOW;
    localparam cmpd_tl_t    H   = CMPD_TL_HIGH;
    localparam cmpd_tl_t    F   = CMPD_TL_FLOAT;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    // Clock, reset and pin requests
    logic     sys_clk, arst_n;
    cmpd_tl_t prim_req, sec_req, rng_req, swg_req, edg_req, dly_req;
    // Pad sense
    logic primary_sel_level, primary_sel_floating, secondary_sel_level;
    logic secondary_sel_floating, range_mode_level, range_mode_floating;
    logic swing_pin_level, swing_pin_floating, edge_pin_level;
    logic edge_pin_floating, delay_pin_level, delay_pin_floating;
    // Settings and serial taps
    logic extended_mode_r, output_swing_level_r, output_transition_edge_r;
    logic ddr_clock_r, calibration_delay_select_r, dual_edge_sampling_r;
    logic input_full_scale_range_r, swing_float_error_r, serial_clock_r;
    logic serial_line_data_r, serial_select_n_r;
    // Register bus
    logic [3:0]  s_awaddr, s_wstrb, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd_v;
    logic [1:0]  s_bresp, s_rresp, rsp_v;
    logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready;
    // Scoreboard
    int          fail_count, checked;
    logic [5:0]  ctrl_exp;
    logic [10:0] exp_v, msk_v;

    cmpd_strap_model pins (
        .sys_clk, .prim_req, .sec_req, .rng_req, .swg_req, .edg_req, .dly_req,
        .primary_sel_level, .primary_sel_floating, .secondary_sel_level,
        .secondary_sel_floating, .range_mode_level, .range_mode_floating,
        .swing_pin_level, .swing_pin_floating, .edge_pin_level,
        .edge_pin_floating, .delay_pin_level, .delay_pin_floating
    );

    cmpd_decoder dut (
        .sys_clk, .arst_n, .primary_sel_level, .primary_sel_floating,
        .secondary_sel_level, .secondary_sel_floating, .range_mode_level,
        .range_mode_floating, .swing_pin_level, .swing_pin_floating,
        .edge_pin_level, .edge_pin_floating, .delay_pin_level,
        .delay_pin_floating, .extended_mode_r, .output_swing_level_r,
        .output_transition_edge_r, .ddr_clock_r, .calibration_delay_select_r,
        .dual_edge_sampling_r, .input_full_scale_range_r, .swing_float_error_r,
        .serial_clock_r, .serial_line_data_r, .serial_select_n_r,
        .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
        .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready
    );

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Counts and verdict
    task conclude;
        $display("Counts: checked=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // Masked four-state compare
    task chk(input logic [31:0] got, input logic [31:0] exp,
             input logic [31:0] msk);
        checked++;
        if (((got ^ exp) & msk) !== 32'h0) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait guard
    task guard(input int n);
        if (n > 100) begin
            fail_count++;
            $display("Timeout waiting for bus answer at %0t", $time);
            conclude;
        end
    endtask : guard

    // Write one word, return the response code
    task axi_wr(input logic [3:0] a, input logic [31:0] d,
                input logic [3:0] st, output logic [1:0] resp);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge sys_clk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= d;
        s_wstrb <= st;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            n++;
            guard(n);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            if (s_bready && s_bvalid === 1'b1) begin
                resp = s_bresp;
                s_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_wr

    // Read one word with its response code
    task axi_rd(input logic [3:0] a, output logic [31:0] d,
                output logic [1:0] resp);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge sys_clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            n++;
            guard(n);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rready && s_rvalid === 1'b1) begin
                d = s_rdata;
                resp = s_rresp;
                s_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : axi_rd

    // Apply pin states, then compare every decoded output except swing, edge and range in pin mode when that pin is open
    task set_pins(input cmpd_tl_t p, s, r, w, e, d);
        logic ext;
        @(posedge sys_clk);
        prim_req <= p;
        sec_req <= s;
        rng_req <= r;
        swg_req <= w;
        edg_req <= e;
        dly_req <= d;
        repeat (3) @(posedge sys_clk);
        ext = (p == L) || (p == F && s != L && r == F);
        msk_v = 11'h7FF;
        if (ext) begin
            exp_v = {1'b1, ctrl_exp[0], ctrl_exp[1], ctrl_exp[2], ctrl_exp[3],
                     ctrl_exp[4], ctrl_exp[5], 1'b0, w == H, e == H, d != L};
        end else begin
            exp_v = {1'b0, w == H, e == H, e == F, d == H, d == F, r == H,
                     w == F, 3'b001};
            msk_v[9] = (w != F);
            msk_v[8] = (e != F);
            msk_v[4] = (r != F);
        end
        chk({21'h0, extended_mode_r, output_swing_level_r,
             output_transition_edge_r, ddr_clock_r, calibration_delay_select_r,
             dual_edge_sampling_r, input_full_scale_range_r,
             swing_float_error_r, serial_clock_r, serial_line_data_r,
             serial_select_n_r}, {21'h0, exp_v}, {21'h0, msk_v});
    endtask : set_pins

    // Reset values and bus readiness after release
    task t_reset;
        repeat (6) @(posedge sys_clk);
        chk({30'h0, extended_mode_r, serial_select_n_r}, 32'h1, ALL);
        chk({27'h0, s_awready, s_wready, s_arready, s_bvalid, s_rvalid},
            32'h0, ALL);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({27'h0, s_awready, s_wready, s_arready, s_bvalid, s_rvalid},
            32'h1C, ALL);
        $display("t_reset done");
    endtask : t_reset

    // Every combination of the three mode straps
    task t_mode;
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 3; s++) begin
                for (int r = 0; r < 3; r++) begin
                    set_pins(cmpd_tl_t'(p), cmpd_tl_t'(s),
                             cmpd_tl_t'(r), H, L, H);
                end
            end
        end
        $display("t_mode done");
    endtask : t_mode

    // Serial mode: register settings, pin reuse, bus errors
    task t_serial;
        set_pins(L, H, H, L, L, L);
        axi_wr(CMPD_CTRL_OFS, 32'h0000_001E, 4'h1, rsp_v);
        chk({30'h0, rsp_v}, {30'h0, CMPD_RESP_OK}, ALL);
        ctrl_exp = 6'h1E;
        for (int i = 0; i < 8; i++) begin
            set_pins(L, H, H, i[0] ? H : L, i[1] ? H : L,
                     i[2] ? H : L);
        end
        axi_wr(CMPD_CTRL_OFS, ALL, 4'h0, rsp_v);
        axi_rd(CMPD_CTRL_OFS, rd_v, rsp_v);
        chk(rd_v, 32'h0000_001E, ALL);
        axi_wr(CMPD_STAT_OFS, ALL, 4'hF, rsp_v);
        chk({30'h0, rsp_v}, {30'h0, CMPD_RESP_OK}, ALL);
        axi_rd(CMPD_STAT_OFS, rd_v, rsp_v);
        chk(rd_v, 32'h0000_1E01, ALL);
        axi_wr(4'h8, ALL, 4'hF, rsp_v);
        chk({30'h0, rsp_v}, {30'h0, CMPD_RESP_ERR}, ALL);
        axi_rd(4'hC, rd_v, rsp_v);
        chk(rd_v, 32'h0, ALL);
        chk({30'h0, rsp_v}, {30'h0, CMPD_RESP_ERR}, ALL);
        $display("t_serial done");
    endtask : t_serial

    // Pin mode: every edge and delay level, swing and range low and high, register image must not leak
    task t_pins;
        for (int w = 0; w < 2; w++) begin
            for (int e = 0; e < 3; e++) begin
                for (int d = 0; d < 3; d++) begin
                    for (int r = 0; r < 2; r++) begin
                        set_pins(H, F, cmpd_tl_t'(r), cmpd_tl_t'(w),
                                 cmpd_tl_t'(e),
                                 cmpd_tl_t'(d));
                    end
                end
            end
        end
        axi_wr(CMPD_CTRL_OFS, 32'h0000_0000, 4'h1, rsp_v);
        chk({30'h0, rsp_v}, {30'h0, CMPD_RESP_OK}, ALL);
        ctrl_exp = 6'h00;
        axi_rd(CMPD_CTRL_OFS, rd_v, rsp_v);
        chk(rd_v, 32'h0, ALL);
        set_pins(H, F, H, H, F, F);
        set_pins(H, H, H, F, L, F);
        axi_rd(CMPD_STAT_OFS, rd_v, rsp_v);
        chk(rd_v, 32'h0000_3002, 32'hFFFF_FEFF);
        $display("t_pins done");
    endtask : t_pins

    // Main sequence
    initial begin
        fail_count = 0;
        checked = 0;
        ctrl_exp = CMPD_CTRL_RST;
        arst_n = 1'b0;
        prim_req = F;
        sec_req = F;
        rng_req = F;
        swg_req = F;
        edg_req = F;
        dly_req = F;
        {s_awaddr, s_wstrb, s_araddr, s_wdata} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        t_reset;
        t_mode;
        t_serial;
        t_pins;
        conclude;
    end
endmodule : control_mode_pin_decoder_test
